// File: can_irq_map.svh
// Purpose: Offsets, field positions, reset values and limits of the CAN
//          interrupt and power-mode block
// Assumes: Word-aligned AHB-Lite register window, 8-bit offsets
// Notes:   Definitions only
`ifndef CAN_IRQ_MAP_SVH
`define CAN_IRQ_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CAN_OFF_CTRL     8'h00
`define CAN_OFF_RXFLAG   8'h04
`define CAN_OFF_RXIEN    8'h08
`define CAN_OFF_TXFLAG   8'h0c
`define CAN_OFF_TXIEN    8'h10
`define CAN_OFF_ERRCNT   8'h14
`define CAN_OFF_CFG      8'h18

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CAN_CTRL_SLEEP_REQUEST   0
`define CAN_CTRL_SRST    1
`define CAN_CTRL_SLEEP_ACK   2
`define CAN_CTRL_ABT_LO  4
`define CAN_CTRL_MODE_LO 8

// ----------------------------------------
// Receiver flag bit positions and transmit error count field
// ----------------------------------------
`define CAN_RF_RXF       0
`define CAN_RF_OVR       1
`define CAN_RF_BOFF      2
`define CAN_RF_TPASS     3
`define CAN_RF_RPASS     4
`define CAN_RF_TWARN     5
`define CAN_RF_RWARN     6
`define CAN_RF_WAKE      7
`define CAN_ERR_TX_LO    16

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define CAN_RST_SRST     1'b1
`define CAN_RST_CFG      32'h0000_0000
`define CAN_WARN_LIMIT   9'h060
`define CAN_PASS_LIMIT   9'h07f
`define CAN_BOFF_LIMIT   9'h0ff
`define CAN_RUN_LAST     4'ha
`define CAN_BOFF_LAST    8'h7f

`endif

// File: can_irq_pkg.sv
// Purpose: Types of the CAN interrupt and power-mode block
// Assumes: Map header not included; field widths written out here
// Notes:   All state of the block is one packed struct
package can_irq_pkg;

   typedef enum logic [5:0] {
      ST_NORMAL  = 6'h01,
      ST_SYNC    = 6'h02,
      ST_SLPPEND = 6'h04,
      ST_SLEEP   = 6'h08,
      ST_SOFTRST = 6'h10,
      ST_PDOWN   = 6'h20
   } mode_t;

   typedef struct packed {
      mode_t       mode;
      logic        sleep_request;
      logic        soft_reset_lock;
      logic [7:0]  rflag;
      logic [7:0]  rien;
      logic [7:0]  cond_prev;
      logic [2:0]  tx_buf_empty;
      logic [2:0]  tx_ien;
      logic [2:0]  abort_req;
      logic [31:0] cfg;
      logic        bg_full;
      logic        copy;
      logic        boff_rec;
      logic [1:0]  rx_sync;
      logic        rx_prev;
      logic [3:0]  rec_run;
      logic [7:0]  boff_cnt;
      logic        can_tx;
      logic        ap_valid;
      logic        ap_write;
      logic [7:0]  ap_addr;
      logic        rd_wait;
      logic [31:0] rdata;
   } state_t;

endpackage

// File: can_irq_and_power_mode_ctrl.sv
// Purpose: Interrupt flags, acknowledge, config lock and power modes of a
//          CAN controller, with an AHB-Lite register slave
// Assumes: Protocol engine on the same clock; CAN receive pin is async
// Notes:   Error counters come from the engine and are read-only here
//
// What this block does
// - Four interrupt outputs fed by eleven flags, each with its enable.
// - Transmit interrupt while any enabled buffer-empty flag is set.
// - Good received frame sets receive-full and raises receive interrupt.
// - Bus activity in sleep sets wake flag; interrupt needs ack and enable.
// - Warning flags at count 96; passive flags above 127.
// - Transmit count above 255 means bus-off and sets its flag.
// - Error, receive and transmit interrupts stay high while any enabled flag is set.
// - Writing one clears a flag; writing zero leaves it.
// - A clear is ignored while the flag's condition persists.
// - Error counters cannot be altered by software.
// - Configuration writes only take effect while soft reset is set.
// - Transmit pin recessive in sleep, soft reset and power down.
// - Mode: stop gives power down, else soft reset bit, else sequenced by sleep request, traffic and wake.
// - Sleep and soft reset gate engine clocks, registers stay usable.
// - CPU stop: abort traffic, stop clocks, refuse register access.
// - Sleep request waits for traffic to finish, then ack is set.
// - Bus-off recovery count pauses in sleep, resumes after wake.
// - In sleep, copies and aborts wait until wake-up.
// - Wake on activity, request clear or soft reset; then 11 recessive bits.
// - Setting soft reset halts traffic at once, even mid-frame.
// - CPU wait leaves the block operating normally.
// - Third accepted frame with both buffers full flags overrun, discarded.
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "can_irq_map.svh"

module can_irq_and_power_mode_ctrl (
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic        i_clk_en,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   input  wire logic        i_cpu_stop,
   input  wire logic        i_cpu_wait,
   input  wire logic        i_can_rx,
   input  wire logic        i_core_tx,
   input  wire logic        i_bit_tick,
   input  wire logic        i_rx_frame_ok,
   input  wire logic        i_rx_busy,
   input  wire logic        i_tx_busy,
   input  wire logic [2:0]  i_tx_done,
   input  wire logic [7:0]  i_rx_err_cnt,
   input  wire logic [8:0]  i_tx_err_cnt,
   output logic             o_can_tx,
   output logic             o_irq_wake,
   output logic             o_irq_err,
   output logic             o_irq_rx,
   output logic             o_irq_tx,
   output can_irq_pkg::mode_t o_mode,
   output logic             o_core_clk_en,
   output logic             o_core_halt,
   output logic [2:0]       o_tx_sched,
   output logic [2:0]       o_abort_req,
   output logic             o_copy_bg_fg,
   output logic             o_busoff_recover,
   output logic [31:0]      o_config
);
   import can_irq_pkg::*;

   state_t q;
   state_t d;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Mode groups
   function automatic logic engine_on(input mode_t m);
      engine_on = (m == ST_NORMAL) || (m == ST_SYNC) || (m == ST_SLPPEND);
   endfunction

   function automatic logic on_bus(input mode_t m);
      on_bus = (m == ST_NORMAL) || (m == ST_SLPPEND);
   endfunction

   function automatic logic [31:0] rd_word(input state_t s,
                                           input logic [7:0] rx_c,
                                           input logic [8:0] tx_c);
      rd_word = 32'h0000_0000;
      case (s.ap_addr)
         `CAN_OFF_CTRL: begin
            rd_word[`CAN_CTRL_SLEEP_REQUEST] = s.sleep_request;
            rd_word[`CAN_CTRL_SRST] = s.soft_reset_lock;
            rd_word[`CAN_CTRL_SLEEP_ACK] = (s.mode == ST_SLEEP);
            rd_word[`CAN_CTRL_ABT_LO +: 3] = s.abort_req;
            rd_word[`CAN_CTRL_MODE_LO +: 6] = s.mode;
         end
         `CAN_OFF_RXFLAG: rd_word[7:0] = s.rflag;
         `CAN_OFF_RXIEN:  rd_word[7:0] = s.rien;
         `CAN_OFF_TXFLAG: rd_word[2:0] = s.tx_buf_empty;
         `CAN_OFF_TXIEN:  rd_word[2:0] = s.tx_ien;
         `CAN_OFF_ERRCNT: begin
            rd_word[7:0] = rx_c;
            rd_word[`CAN_ERR_TX_LO +: 9] = tx_c;
         end
         `CAN_OFF_CFG:    rd_word = s.cfg;
         default:         rd_word = 32'h0000_0000;
      endcase
   endfunction

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   logic       rx_s;
   logic       wr_now;
   logic [7:0] cond;
   logic [7:0] rise;
   logic [7:0] set;
   logic [7:0] clr;
   logic [2:0] txclr;
   logic       wake_ev;
   logic       ovr_ev;
   logic       rxf_set;
   logic       rxf_now;
   logic       run11;
   logic       tx_pend;
   logic [8:0] rx9;

   always_comb begin
      d = q;
      rx_s = q.rx_sync[1];
      rx9 = {1'b0, i_rx_err_cnt};
      // Refused entirely while powered down
      wr_now = q.ap_valid && q.ap_write && (q.mode != ST_PDOWN);
      clr = 8'h00;
      txclr = 3'h0;
      wake_ev = 1'b0;
      ovr_ev = 1'b0;
      rxf_set = 1'b0;
      run11 = 1'b0;
      rxf_now = 1'b0;
      set = 8'h00;
      tx_pend = (~q.tx_buf_empty != 3'h0) || i_tx_busy;
      cond = 8'h00;
      cond[`CAN_RF_RWARN] = rx9 >= `CAN_WARN_LIMIT;
      cond[`CAN_RF_TWARN] = i_tx_err_cnt >= `CAN_WARN_LIMIT;
      cond[`CAN_RF_RPASS] = rx9 > `CAN_PASS_LIMIT;
      cond[`CAN_RF_TPASS] = i_tx_err_cnt > `CAN_PASS_LIMIT;
      cond[`CAN_RF_BOFF] = i_tx_err_cnt > `CAN_BOFF_LIMIT;
      rise = cond & ~q.cond_prev;
      if (i_clk_en) begin
         d.copy = 1'b0;
         d.boff_rec = 1'b0;
         d.cond_prev = cond;
         d.rx_sync = {q.rx_sync[0], i_can_rx};
         d.rx_prev = rx_s;

         // Bus slave: address phase, read wait state, write data phase
         if (i_hready) begin
            d.ap_valid = i_hsel && i_htrans[1];
            d.ap_write = i_hwrite;
            d.ap_addr = i_haddr[7:0];
            d.rd_wait = 1'b0;
         end else if (q.ap_valid && !q.ap_write) begin
            // Reads give zero in power down
            d.rdata = (q.mode == ST_PDOWN) ? 32'h0000_0000 :
                      rd_word(q, i_rx_err_cnt, i_tx_err_cnt);
            d.rd_wait = 1'b1;
         end

         if (wr_now) begin
            case (q.ap_addr)
               `CAN_OFF_CTRL: begin
                  d.sleep_request = i_hwdata[`CAN_CTRL_SLEEP_REQUEST];
                  d.soft_reset_lock = i_hwdata[`CAN_CTRL_SRST];
                  d.abort_req = q.abort_req | (i_hwdata[`CAN_CTRL_ABT_LO +: 3] & ~q.tx_buf_empty);
               end
               `CAN_OFF_RXFLAG: clr = i_hwdata[7:0];
               `CAN_OFF_RXIEN:  d.rien = i_hwdata[7:0];
               `CAN_OFF_TXFLAG: txclr = i_hwdata[2:0];
               `CAN_OFF_TXIEN:  d.tx_ien = i_hwdata[2:0];
               `CAN_OFF_CFG: begin
                  if (q.soft_reset_lock) begin
                     d.cfg = i_hwdata;
                  end
               end
               default: d.cfg = q.cfg;
            endcase
         end
         clr = clr & ~cond;

         wake_ev = (q.mode == ST_SLEEP) && q.rx_prev && !rx_s;

         rxf_now = q.rflag[`CAN_RF_RXF] && !clr[`CAN_RF_RXF];
         if (i_rx_frame_ok && on_bus(q.mode)) begin
            if (!rxf_now) begin
               rxf_set = 1'b1;
               d.copy = 1'b1;
            end else if (!q.bg_full) begin
               d.bg_full = 1'b1;
            end else begin
               ovr_ev = 1'b1;
            end
         end else if (q.bg_full && !rxf_now && engine_on(q.mode)) begin
            rxf_set = 1'b1;
            d.bg_full = 1'b0;
            d.copy = 1'b1;
         end

         set = rise;
         set[`CAN_RF_WAKE] = wake_ev;
         set[`CAN_RF_OVR] = ovr_ev;
         set[`CAN_RF_RXF] = rxf_set;
         // Set wins over a same-cycle clear
         d.rflag = (q.rflag & ~clr) | set;

         // Buffer empty after send or abort
         d.tx_buf_empty = (q.tx_buf_empty & ~txclr) | i_tx_done;
         d.abort_req = d.abort_req & ~i_tx_done;

         // Recessive bit runs for sync and bus-off recovery
         if (engine_on(q.mode) && i_bit_tick) begin
            if (rx_s) begin
               run11 = (q.rec_run == `CAN_RUN_LAST);
               d.rec_run = run11 ? 4'h0 : q.rec_run + 4'h1;
            end else begin
               d.rec_run = 4'h0;
            end
         end
         // Only advances while engine clocks run
         if (!cond[`CAN_RF_BOFF]) begin
            d.boff_cnt = 8'h00;
         end else if (run11) begin
            d.boff_rec = (q.boff_cnt == `CAN_BOFF_LAST);
            d.boff_cnt = d.boff_rec ? 8'h00 : q.boff_cnt + 8'h01;
         end

         // Mode sequencing; stop and soft reset take priority
         if (i_cpu_stop) begin
            d.mode = ST_PDOWN;
         end else if (d.soft_reset_lock) begin
            d.mode = ST_SOFTRST;
         end else begin
            case (q.mode)
               ST_PDOWN, ST_SOFTRST: begin
                  d.mode = ST_SYNC;
                  d.rec_run = 4'h0;
               end
               ST_SYNC: begin
                  if (run11) begin
                     d.mode = ST_NORMAL;
                  end
               end
               ST_NORMAL: begin
                  if (q.sleep_request) begin
                     d.mode = ST_SLPPEND;
                  end
               end
               ST_SLPPEND: begin
                  if (!q.sleep_request) begin
                     d.mode = ST_NORMAL;
                  end else if (!tx_pend && !i_rx_busy) begin
                     d.mode = ST_SLEEP;
                  end
               end
               // Wake-up sources
               // Leave one cycle after the wake flag, so ack and flag meet
               // Limitation: a wake flag left set wakes at once; clear it first
               ST_SLEEP: begin
                  if (q.rflag[`CAN_RF_WAKE] || !d.sleep_request) begin
                     d.mode = ST_SYNC;
                     d.rec_run = 4'h0;
                  end
               end
               default: d.mode = ST_SOFTRST;
            endcase
         end

         d.can_tx = on_bus(d.mode) ? i_core_tx : 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '{mode: ST_SOFTRST, soft_reset_lock: `CAN_RST_SRST, cfg: `CAN_RST_CFG,
                tx_buf_empty: 3'h7, rx_sync: 2'h3, rx_prev: 1'b1, can_tx: 1'b1,
                default: '0};
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_hreadyout = !(q.ap_valid && !q.ap_write && !q.rd_wait);
   assign o_hresp = 1'b0;
   assign o_hrdata = q.rdata;
   assign o_can_tx = q.can_tx;
   // Flag AND enable, ORed per output
   assign o_irq_wake = q.rflag[`CAN_RF_WAKE] && q.rien[`CAN_RF_WAKE] && (q.mode == ST_SLEEP);
   assign o_irq_err = |(q.rflag[`CAN_RF_RWARN:`CAN_RF_OVR] & q.rien[`CAN_RF_RWARN:`CAN_RF_OVR]);
   assign o_irq_rx = q.rflag[`CAN_RF_RXF] && q.rien[`CAN_RF_RXF];
   assign o_irq_tx = |(q.tx_buf_empty & q.tx_ien);
   assign o_mode = q.mode;
   assign o_core_clk_en = engine_on(q.mode);
   assign o_core_halt = (q.mode == ST_SOFTRST) || (q.mode == ST_PDOWN);
   assign o_tx_sched = ~q.tx_buf_empty;
   assign o_abort_req = engine_on(q.mode) ? q.abort_req : 3'h0;
   assign o_copy_bg_fg = q.copy;
   assign o_busoff_recover = q.boff_rec;
   assign o_config = q.cfg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   AST_TX_IRQ: assert property (o_irq_tx == (|(q.tx_buf_empty & q.tx_ien)))
      else $error("transmit interrupt does not follow enabled empty flags");
   AST_WAKE_GATE: assert property (o_irq_wake |-> q.mode == ST_SLEEP && q.rien[`CAN_RF_WAKE])
      else $error("wake interrupt without ack and enable");
   AST_RX_FULL: assert property (i_clk_en && i_rx_frame_ok && on_bus(q.mode) && !q.rflag[`CAN_RF_RXF]
      |=> q.rflag[`CAN_RF_RXF] && o_copy_bg_fg)
      else $error("received frame did not set receive-full");
   AST_W1C_HOLD: assert property (i_clk_en && wr_now && q.ap_addr == `CAN_OFF_RXFLAG
      && i_hwdata[`CAN_RF_RWARN] && cond[`CAN_RF_RWARN] |=> q.rflag[`CAN_RF_RWARN])
      else $error("warning flag cleared while its condition holds");
   AST_TX_RECESSIVE: assert property (!on_bus(q.mode) |-> o_can_tx)
      else $error("transmit pin driven outside bus modes");
   AST_PDOWN: assert property (i_clk_en && i_cpu_stop |=> q.mode == ST_PDOWN && o_core_halt)
      else $error("stop did not enter power down");
   AST_CFG_LOCK: assert property (!q.soft_reset_lock |=> $stable(q.cfg))
      else $error("configuration changed while unlocked");
   AST_SLEEP_WAIT: assert property (i_clk_en && q.mode == ST_SLPPEND && !i_cpu_stop
      && !q.soft_reset_lock && (i_tx_busy || i_rx_busy) |=> q.mode != ST_SLEEP)
      else $error("sleep entered during traffic");
   AST_ERR_IRQ: assert property (q.rflag[`CAN_RF_BOFF] && q.rien[`CAN_RF_BOFF] |-> o_irq_err)
      else $error("bus-off flag did not raise error interrupt");

   COV_SLEEP_WAKE: cover property (q.mode == ST_SLEEP ##1 q.mode == ST_SYNC);
   COV_OVERRUN: cover property ($rose(q.rflag[`CAN_RF_OVR]));
   COV_RECOVER: cover property (o_busoff_recover);
   COV_JOIN: cover property (q.mode == ST_SYNC ##1 q.mode == ST_NORMAL);
   COV_WAKE_IRQ: cover property (o_irq_wake);

endmodule

// File: can_bus_model.sv
// Purpose: CAN bus behind the transceiver, with the other nodes
// Assumes: Bus pulled recessive (1); all nodes wired-AND
// Notes:   Bit tick stands for the sample point of each bus bit
`timescale 1ns/1ns
module can_bus_model #(
   parameter int BIT_CYC = 4
) (
   input  wire logic i_clock,
   input  wire logic i_rst_b,
   input  wire logic i_node_tx,
   input  wire logic i_other_dom,
   output logic      o_can_rx,
   output logic      o_bit_tick
);
   logic [7:0] div_q;
   logic [7:0] div_d;

   // Any dominant node wins; a released bus floats back to recessive
   assign o_can_rx   = i_node_tx & ~i_other_dom;
   assign o_bit_tick = (div_q == 8'(BIT_CYC - 1));
   assign div_d      = o_bit_tick ? 8'h00 : div_q + 8'h01;

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_d;
      end
   end
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench of the CAN interrupt and power-mode block
// Assumes: Single AHB-Lite slave; engine inputs driven from here
// Notes:   Bus model makes the receive line; 4 clocks per CAN bit
`timescale 1ns/1ns
`include "can_irq_map.svh"
module tb_top;
   import can_irq_pkg::*;
   localparam logic [7:0] A_CTL = `CAN_OFF_CTRL;
   localparam logic [7:0] A_RF  = `CAN_OFF_RXFLAG;
   localparam logic [7:0] A_RE  = `CAN_OFF_RXIEN;
   localparam logic [7:0] A_TF  = `CAN_OFF_TXFLAG;
   localparam logic [7:0] A_TE  = `CAN_OFF_TXIEN;
   localparam logic [7:0] A_EC  = `CAN_OFF_ERRCNT;
   localparam logic [7:0] A_CF  = `CAN_OFF_CFG;
   logic        clock, rst_b, hsel, hwrite, rdy, hresp, stop, waitm;
   logic        core_tx, rx_ok, rx_busy, tx_busy, dom, can_rx, tick, can_tx;
   logic        irq_w, irq_e, irq_r, irq_t, cen, halt, copy, bor;
   logic        clk_en;
   logic        saw_w = 1'b0;
   logic [1:0]  htrans;
   logic [2:0]  tx_done, sched, abt;
   logic [7:0]  rx_err;
   logic [8:0]  tx_err;
   logic [31:0] haddr, hwdata, hrdata, cfg, rd_s;
   mode_t       mode;
   int          n_mismatch, comparisons;

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   can_bus_model bus_u (.i_clock(clock), .i_rst_b(rst_b), .i_node_tx(can_tx), .i_other_dom(dom),
      .o_can_rx(can_rx), .o_bit_tick(tick));

   can_irq_and_power_mode_ctrl dut_u (
      .i_clock(clock), .i_rst_b(rst_b), .i_clk_en(clk_en), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy),
      .o_hreadyout(rdy), .o_hresp(hresp), .o_hrdata(hrdata), .i_cpu_stop(stop), .i_cpu_wait(waitm),
      .i_can_rx(can_rx), .i_core_tx(core_tx), .i_bit_tick(tick), .i_rx_frame_ok(rx_ok),
      .i_rx_busy(rx_busy), .i_tx_busy(tx_busy), .i_tx_done(tx_done), .i_rx_err_cnt(rx_err),
      .i_tx_err_cnt(tx_err), .o_can_tx(can_tx), .o_irq_wake(irq_w), .o_irq_err(irq_e),
      .o_irq_rx(irq_r), .o_irq_tx(irq_t), .o_mode(mode), .o_core_clk_en(cen), .o_core_halt(halt),
      .o_tx_sched(sched), .o_abort_req(abt), .o_copy_bg_fg(copy), .o_busoff_recover(bor),
      .o_config(cfg));

   // Wake interrupt lasts one cycle; catch it between edges
   always @(negedge clock) begin
      if (irq_w === 1'b1) begin
         saw_w <= 1'b1;
      end
   end

   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   function automatic logic [31:0] ctl(input mode_t m, input logic [7:0] b);
      return {18'h0, m, b};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Hold the phase until ready is seen high at a rising edge
   task automatic rdy_wait;
      @(negedge clock);
      while (rdy !== 1'b1) @(negedge clock);
      rd_s = hrdata;
      @(posedge clock);
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      rdy_wait();
      htrans <= 2'h0;
      hwdata <= d;
      rdy_wait();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      @(negedge clock);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      @(negedge clock);
      chk(rd_s, e);
   endtask

   task automatic wait_mode(input mode_t m);
      int n;
      n = 0;
      @(negedge clock);
      while (mode !== m && n < 300) begin
         @(negedge clock);
         n++;
      end
      chk(32'(mode), 32'(m));
   endtask

   task automatic frame;
      @(posedge clock);
      rx_ok <= 1'b1;
      @(posedge clock);
      rx_ok <= 1'b0;
      repeat (2) @(negedge clock);
   endtask

   task automatic errs(input logic [8:0] t, input logic [7:0] r, input logic [31:0] e);
      @(posedge clock);
      tx_err <= t;
      rx_err <= r;
      repeat (3) @(negedge clock);
      rdc(A_RF, e);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      rdc(A_CTL, ctl(ST_SOFTRST, 8'h02));
      rdc(A_TF, 32'h7);
      rdc(A_EC, 32'h0);
      chk({hresp, irq_w, irq_e, irq_r, irq_t, can_tx, halt}, 32'h3);
      $display("test reset finished");
   endtask

   task automatic t_cfg;
      wr(A_CF, 32'ha5c3_0f1e);
      rdc(A_CF, 32'ha5c3_0f1e);
      wr(A_CTL, 32'h0);
      repeat (32) @(negedge clock);
      chk(32'(mode), 32'(ST_SYNC));
      wait_mode(ST_NORMAL);
      wr(A_CF, 32'h1234_5678);
      rdc(A_CF, 32'ha5c3_0f1e);
      chk(cfg, 32'ha5c3_0f1e);
      $display("test config lock finished");
   endtask

   task automatic t_tx;
      @(posedge clock);
      waitm <= 1'b1;
      chk(32'(irq_t), 32'h0);
      wr(A_TE, 32'h2);
      chk(32'(irq_t), 32'h1);
      wr(A_TF, 32'h1);
      chk({irq_t, sched}, 32'h9);
      wr(A_TF, 32'h0);
      rdc(A_TF, 32'h6);
      wr(A_TF, 32'h2);
      chk({irq_t, sched}, 32'h3);
      @(posedge clock);
      tx_done <= 3'h3;
      @(posedge clock);
      tx_done <= 3'h0;
      repeat (2) @(negedge clock);
      chk({irq_t, sched}, 32'h8);
      wr(A_TF, 32'h1);
      @(posedge clock);
      clk_en <= 1'b0;
      tx_done <= 3'h1;
      @(posedge clock);
      tx_done <= 3'h0;
      @(posedge clock);
      clk_en <= 1'b1;
      repeat (2) @(negedge clock);
      chk(32'(sched), 32'h1);
      @(posedge clock);
      tx_done <= 3'h1;
      @(posedge clock);
      tx_done <= 3'h0;
      repeat (2) @(negedge clock);
      chk(32'(sched), 32'h0);
      $display("test transmit irq finished");
   endtask

   task automatic t_err;
      int n;
      wr(A_RE, 32'h7c);
      errs(9'd95, 8'd95, 32'h0);
      errs(9'd96, 8'd95, 32'h20);
      chk(32'(irq_e), 32'h1);
      errs(9'd127, 8'd96, 32'h60);
      errs(9'd128, 8'd128, 32'h78);
      errs(9'd255, 8'd128, 32'h78);
      errs(9'd256, 8'd128, 32'h7c);
      // Recovery needs 128 runs of 11 recessive bits, 4 clocks each
      n = 0;
      while (bor !== 1'b1 && n < 6000) begin
         @(negedge clock);
         n++;
      end
      chk(32'(bor), 32'h1);
      chk(32'(n > 5400), 32'h1);
      wr(A_RF, 32'h7c);
      rdc(A_RF, 32'h7c);
      wr(A_EC, 32'h0);
      rdc(A_EC, 32'h0100_0080);
      errs(9'd0, 8'd0, 32'h7c);
      wr(A_RF, 32'h7c);
      rdc(A_RF, 32'h0);
      chk(32'(irq_e), 32'h0);
      $display("test error flags finished");
   endtask

   task automatic t_rx;
      wr(A_RE, 32'h3);
      frame();
      chk({irq_r, irq_e}, 32'h2);
      frame();
      rdc(A_RF, 32'h1);
      frame();
      rdc(A_RF, 32'h3);
      chk({irq_r, irq_e}, 32'h3);
      wr(A_RF, 32'h2);
      wr(A_RF, 32'h1);
      rdc(A_RF, 32'h1);
      wr(A_RF, 32'h1);
      rdc(A_RF, 32'h0);
      @(posedge clock);
      waitm <= 1'b0;
      $display("test receive finished");
   endtask

   task automatic t_sleep;
      wr(A_RE, 32'h80);
      @(posedge clock);
      tx_busy <= 1'b1;
      rx_busy <= 1'b1;
      wr(A_CTL, 32'h1);
      rdc(A_CTL, ctl(ST_SLPPEND, 8'h01));
      @(posedge clock);
      tx_busy <= 1'b0;
      rx_busy <= 1'b0;
      core_tx <= 1'b0;
      wait_mode(ST_SLEEP);
      rdc(A_CTL, ctl(ST_SLEEP, 8'h05));
      chk({can_tx, cen, irq_w}, 32'h4);
      wr(A_TF, 32'h1);
      wr(A_CTL, 32'h11);
      chk({sched, abt}, 32'h8);
      @(posedge clock);
      core_tx <= 1'b1;
      dom <= 1'b1;
      repeat (3) @(posedge clock);
      dom <= 1'b0;
      wait_mode(ST_SYNC);
      chk(32'(abt), 32'h1);
      chk(32'(saw_w), 32'h1);
      wr(A_CTL, 32'h0);
      @(posedge clock);
      tx_done <= 3'h1;
      @(posedge clock);
      tx_done <= 3'h0;
      wait_mode(ST_NORMAL);
      rdc(A_RF, 32'h80);
      chk(32'(irq_w), 32'h0);
      wr(A_RF, 32'h80);
      wr(A_CTL, 32'h1);
      wait_mode(ST_SLEEP);
      wr(A_CTL, 32'h0);
      wait_mode(ST_SYNC);
      wait_mode(ST_NORMAL);
      $display("test sleep finished");
   endtask

   task automatic t_stop;
      @(posedge clock);
      core_tx <= 1'b0;
      repeat (3) @(negedge clock);
      chk(32'(can_tx), 32'h0);
      wr(A_CTL, 32'h2);
      wait_mode(ST_SOFTRST);
      chk({can_tx, halt}, 32'h3);
      @(posedge clock);
      core_tx <= 1'b1;
      wr(A_CTL, 32'h0);
      wait_mode(ST_NORMAL);
      @(posedge clock);
      stop <= 1'b1;
      wait_mode(ST_PDOWN);
      chk({can_tx, cen, halt}, 32'h5);
      rdc(A_TF, 32'h0);
      wr(A_CTL, 32'h2);
      @(posedge clock);
      stop <= 1'b0;
      wait_mode(ST_SYNC);
      wait_mode(ST_NORMAL);
      $display("test power down finished");
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Whole run is about six thousand cycles; allow five times that
   initial begin
      #3_000_000;
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      n_mismatch = 0;
      comparisons = 0;
      rst_b <= 1'b0;
      {hsel, hwrite, stop, waitm, rx_ok, rx_busy, tx_busy, dom} <= 8'h0;
      core_tx <= 1'b1;
      clk_en <= 1'b1;
      htrans <= 2'h0;
      haddr <= 32'h0;
      hwdata <= 32'h0;
      tx_done <= 3'h0;
      rx_err <= 8'h0;
      tx_err <= 9'h0;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      t_reset();
      t_cfg();
      t_tx();
      t_err();
      t_rx();
      t_sleep();
      t_stop();
      report_and_stop();
   end
endmodule
